// ---- core/fzg_pkg.sv ----
package fzg_pkg;

    // number of user clocks that can be gated
    localparam int unsigned FZG_NUM_CLKS      = 17;

    // freeze entry time and the cycle count derived at the system clock rate
    localparam int unsigned FZG_ENTRY_TIME_NS = 1000;
    localparam int unsigned FZG_CLK_PERIOD_NS = 40;
    localparam int unsigned FZG_ENTRY_CYCLES  =
        (FZG_ENTRY_TIME_NS + FZG_CLK_PERIOD_NS - 1) / FZG_CLK_PERIOD_NS;
    localparam int unsigned FZG_TIMER_W       = 5;
    localparam logic [4:0]  FZG_ENTRY_LAST    = 5'(FZG_ENTRY_CYCLES - 1);
    localparam logic [4:0]  FZG_TIMER_RST     = 5'h00;

    // reset values of the outputs and synchronisers
    localparam logic        FZG_REQ_N_RST     = 1'b1;
    localparam logic        FZG_LP_RST        = 1'b0;
    localparam logic        FZG_DONE_RST      = 1'b0;
    localparam logic        FZG_SYNC_RST      = 1'b0;

    // controller states
    typedef enum logic [2:0] {
        FZG_IDLE    = 3'h0,
        FZG_GATE    = 3'h1,
        FZG_ENTRY   = 3'h2,
        FZG_FROZEN  = 3'h3,
        FZG_RELEASE = 3'h4
    } fzg_state_t;

endpackage

// ---- core/fzg_freeze_ctrl.sv ----
`timescale 1ns/1ps
module fzg_freeze_ctrl
    import fzg_pkg::*;
(
    input  wire logic                    SYS_CLK,
    input  wire logic                    ARST_N,
    input  wire logic                    HOUSEKEEPING_DONE,
    input  wire logic                    FREEZE_PIN,
    input  wire logic                    FREEZE_BUF_PRESENT,
    input  wire logic [FZG_NUM_CLKS-1:0] USER_CLK,
    output logic      [FZG_NUM_CLKS-1:0] GATED_CLK,
    output logic                         CLK_GATE_REQUEST_N,
    output logic                         LOW_POWER_ENTRY_REQUEST,
    output logic                         FREEZE_ENTERED
);

    logic             pin_meta_reg;
    logic             pin_sync_reg;
    logic             present_meta_reg;
    logic             present_sync_reg;
    logic             freeze_req;
    fzg_state_t       state_reg;
    fzg_state_t       state_next;
    logic [4:0]       timer_reg;
    logic             req_n_reg;
    logic             lp_reg;
    logic             done_reg;

    // true in the states where the user clocks must be held stopped
    function automatic logic is_gating(input fzg_state_t s);
        is_gating = (s == FZG_GATE) || (s == FZG_ENTRY) || (s == FZG_FROZEN);
    endfunction

    // true in the states where the low-power macro is being asked to freeze
    function automatic logic is_entering(input fzg_state_t s);
        is_entering = (s == FZG_ENTRY) || (s == FZG_FROZEN);
    endfunction

    // pin through two flops
    // pin and strap come from outside the clock domain, two flops each
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_meta_reg     <= FZG_SYNC_RST;
            pin_sync_reg     <= FZG_SYNC_RST;
            present_meta_reg <= FZG_SYNC_RST;
            present_sync_reg <= FZG_SYNC_RST;
        end else begin
            pin_meta_reg     <= FREEZE_PIN;
            pin_sync_reg     <= pin_meta_reg;
            present_meta_reg <= FREEZE_BUF_PRESENT;
            present_sync_reg <= present_meta_reg;
        end
    end

    assign freeze_req = pin_sync_reg & present_sync_reg;

    // next state; a dropped pin always wins so release is never delayed
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FZG_IDLE: begin
                if (freeze_req && HOUSEKEEPING_DONE) begin
                    state_next = FZG_GATE;
                end
            end
            FZG_GATE: begin
                if (!freeze_req) begin
                    state_next = FZG_RELEASE;
                end else begin
                    state_next = FZG_ENTRY;
                end
            end
            FZG_ENTRY: begin
                if (!freeze_req) begin
                    state_next = FZG_RELEASE;
                end else if (timer_reg == FZG_ENTRY_LAST) begin
                    state_next = FZG_FROZEN;
                end
            end
            FZG_FROZEN: begin
                if (!freeze_req) begin
                    state_next = FZG_RELEASE;
                end
            end
            FZG_RELEASE: begin
                state_next = FZG_IDLE;
            end
            default: begin
                state_next = FZG_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= FZG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // entry timer runs only in the entry state, cleared anywhere else
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_reg <= FZG_TIMER_RST;
        end else if (state_reg == FZG_ENTRY) begin
            timer_reg <= timer_reg + 5'h01;
        end else begin
            timer_reg <= FZG_TIMER_RST;
        end
    end

    // outputs registered from the next state so they change with the state
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_n_reg <= FZG_REQ_N_RST;
            lp_reg    <= FZG_LP_RST;
            done_reg  <= FZG_DONE_RST;
        end else begin
            req_n_reg <= ~is_gating(state_next);
            lp_reg    <= is_entering(state_next);
            done_reg  <= (state_next == FZG_FROZEN);
        end
    end

    assign CLK_GATE_REQUEST_N      = req_n_reg;
    assign LOW_POWER_ENTRY_REQUEST = lp_reg;
    assign FREEZE_ENTERED          = done_reg;

    // seventeen gated clocks
    // one gate per user clock, all driven from the single request
    for (genvar g = 0; g < FZG_NUM_CLKS; g++) begin : g_gate
        logic cap_reg;
        logic en_lat;

        // capture on own clock
        // single flop on the user clock; the latch below gives it half a cycle to settle
        always_ff @(posedge USER_CLK[g] or negedge ARST_N) begin
            if (!ARST_N) begin
                cap_reg <= FZG_REQ_N_RST;
            end else begin
                cap_reg <= req_n_reg;
            end
        end

        always_latch begin
            if (!USER_CLK[g]) begin
                en_lat = cap_reg;
            end
        end

        // and gate, buffer
        // the AND stands in for the gate cell feeding the global buffer
        assign GATED_CLK[g] = USER_CLK[g] & en_lat;

        a_gate_blocks: assert property (
            @(posedge USER_CLK[g]) disable iff (!ARST_N)
            !cap_reg |-> !en_lat)
            else $error("gate enable open while request captured low");
    end

    a_gate_on_done: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == FZG_IDLE) && freeze_req && HOUSEKEEPING_DONE |=> !req_n_reg)
        else $error("gate request not low after housekeeping done");

    a_lp_after_gate: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        $rose(lp_reg) |-> !req_n_reg && !$past(req_n_reg))
        else $error("entry request raised before gating started");

    a_lp_held: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        lp_reg && freeze_req |=> lp_reg)
        else $error("entry request dropped while freeze still wanted");

    a_entry_time: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        $rose(done_reg) |-> $past(lp_reg, 25) && !$past(lp_reg, 26))
        else $error("freeze entry did not take twenty five cycles");

    a_release_pin: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        is_gating(state_reg) && !freeze_req |=> req_n_reg && !lp_reg)
        else $error("gate request not released after pin drop");

    a_no_buffer: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        !present_sync_reg ##1 !present_sync_reg |=> req_n_reg && !lp_reg)
        else $error("freeze acted without the input buffer present");

    a_pin_path: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        $rose(freeze_req) |-> $past(FREEZE_PIN, 2))
        else $error("freeze request not traced to the pin");

    a_idle_wait: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == FZG_IDLE) && !HOUSEKEEPING_DONE |=> req_n_reg)
        else $error("gating started before housekeeping done");

    a_lp_needs_gate: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        lp_reg |-> !req_n_reg)
        else $error("entry request high while clocks not gated");

    a_entry_timer: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == FZG_ENTRY) |-> (timer_reg <= FZG_ENTRY_LAST))
        else $error("entry timer ran past the entry time");

    a_done_in_entry: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        done_reg |-> lp_reg && !req_n_reg)
        else $error("freeze reported without entry request");

    a_release_idle: assert property (
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == FZG_RELEASE) |=> (state_reg == FZG_IDLE) && req_n_reg)
        else $error("release did not return to idle");

endmodule // fzg_freeze_ctrl

// ---- testbench/fzg_user_clocks.sv ----
`timescale 1ns/1ps
// free running user clocks, each at its own unrelated rate
module fzg_user_clocks
    import fzg_pkg::*;
(
    output logic [FZG_NUM_CLKS-1:0] USER_CLK
);
    // odd half periods keep the domains drifting against each other and the system clock
    for (genvar i = 0; i < FZG_NUM_CLKS; i++) begin : g_clk
        initial begin
            USER_CLK[i] = 1'b0;
            #(3 + i);
            forever #(7.3 + 2.1 * i) USER_CLK[i] = ~USER_CLK[i];
        end
    end
endmodule // fzg_user_clocks

// ---- testbench/fzg_freeze_ctrl_bench.sv ----
`timescale 1ns/1ps
module fzg_freeze_ctrl_bench
    import fzg_pkg::*;
;
    logic                    sys_clk;
    logic                    arst_n;
    logic                    hk_done;
    logic                    pin;
    logic                    strap;
    logic [FZG_NUM_CLKS-1:0] user_clk;
    logic [FZG_NUM_CLKS-1:0] gated_clk;
    logic [FZG_NUM_CLKS-1:0] seen;
    logic [FZG_NUM_CLKS-1:0] gated_last = '0;
    logic [FZG_NUM_CLKS-1:0] cut = '0;
    logic                    seen_clr;
    logic                    req_n;
    logic                    lp_req;
    logic                    entered;
    int                      n_mismatch;
    int                      checks_done;

    fzg_user_clocks clk_u (.USER_CLK(user_clk));
    fzg_freeze_ctrl dut_u (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .HOUSEKEEPING_DONE(hk_done),
        .FREEZE_PIN(pin), .FREEZE_BUF_PRESENT(strap), .USER_CLK(user_clk),
        .GATED_CLK(gated_clk), .CLK_GATE_REQUEST_N(req_n),
        .LOW_POWER_ENTRY_REQUEST(lp_req), .FREEZE_ENTERED(entered)
    );

    // system clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // collects every gated clock that pulsed since the last clear, and every gated
    // pulse that ended while its user clock was still high
    always @(gated_clk or seen_clr) begin
        if (seen_clr) begin
            seen = '0;
        end else begin
            seen = seen | gated_clk;
        end
        cut        = cut | (user_clk & gated_last & ~gated_clk);
        gated_last = gated_clk;
    end

    task automatic check(input logic [FZG_NUM_CLKS-1:0] got,
                         input logic [FZG_NUM_CLKS-1:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 92 system cycles
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end

    initial begin
        {arst_n, hk_done, pin, strap} = '0;
        seen_clr = 1'b1;
        step(6);
        arst_n = 1'b1;
        // no buffer strap: the pin must do nothing
        hk_done = 1'b1;
        pin = 1'b1;
        step(8);
        check(17'(req_n), 17'h00001, "gate request without buffer");
        check(17'(lp_req), 17'h00000, "entry request without buffer");
        // strap present but housekeeping not done: controller waits
        strap = 1'b1;
        hk_done = 1'b0;
        step(8);
        check(17'(req_n), 17'h00001, "gate request before housekeeping");
        hk_done = 1'b1;
        step(1);
        check(17'(req_n), 17'h00000, "gate request after housekeeping");
        check(17'(lp_req), 17'h00000, "entry request before gating");
        step(1);
        check(17'(lp_req), 17'h00001, "entry request after gating");
        step(24);
        check(17'(entered), 17'h00000, "entry too early");
        step(1);
        check(17'(entered), 17'h00001, "entry after one microsecond");
        // all seventeen clocks must now be quiet
        seen_clr = 1'b1;
        step(1);
        seen_clr = 1'b0;
        step(19);
        check(seen, 17'h00000, "gated clocks still running");
        check(17'(lp_req), 17'h00001, "entry request not held");
        // pin drop: two synchroniser edges, then release
        pin = 1'b0;
        step(2);
        check(17'(req_n), 17'h00000, "release too early");
        step(1);
        check(17'({req_n, lp_req, entered}), 17'h00004, "release outputs");
        seen_clr = 1'b1;
        step(1);
        seen_clr = 1'b0;
        step(19);
        check(seen, 17'h1FFFF, "gated clocks not released");
        // sample off the user clock edges; user clock 0 toggles 2.2 ns after this falling edge
        #1;
        check(gated_clk, user_clk, "gates not fully open");
        check(cut, 17'h00000, "gated pulse cut short");
        check(17'(req_n), 17'h00001, "request not back to idle");
        conclude();
    end
endmodule // fzg_freeze_ctrl_bench
